// *** led_ctrl_model.sv ***
// Display controller model that drives the serial on/off chain
`timescale 1ns/1ps
`default_nettype none
module led_ctrl_model (
    input  wire logic                    clk_i,  // System clock
    output var  led_sink_pkg::pins_in_t  pins_o  // Pins toward the block
);
    import led_sink_pkg::*;
    initial pins_o = '0;
    // MSB first, so the first bit ends up at the far end
    task automatic shift_word(input logic [NUM_CH-1:0] w);
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            @(posedge clk_i);
            pins_o.serial_in <= w[i];
            pins_o.shift_clk <= 1'b0;
            @(posedge clk_i);
            pins_o.shift_clk <= 1'b1;
        end
        @(posedge clk_i);
        pins_o.shift_clk <= 1'b0;
        // Idle data is not held at the last level
        pins_o.serial_in <= ~pins_o.serial_in;
    endtask
    // One pulse per update; gap below hold only when a scenario asks
    task automatic strobe(input int gap);
        @(posedge clk_i);
        pins_o.latch_strobe <= 1'b1;
        @(posedge clk_i);
        pins_o.latch_strobe <= 1'b0;
        repeat (gap) @(posedge clk_i);
    endtask
    task automatic set_blank(input logic b);
        @(posedge clk_i);
        pins_o.blank <= b;
        repeat (2) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// *** led_sink_onoff_shift_latch.sv ***
// Serial on/off shift register, latch and blanking for a 16-sink LED driver
// Function
// - Each rising shift clock edge loads serial input into register LSB; one coinciding with a latch strobe rising edge is ignored.
// - Each rising shift clock edge moves all register bits one place toward MSB; one coinciding with a latch strobe rising edge is ignored.
// - Latch strobe rising edge copies the whole shift register into the latch.
// - Same latch strobe edge fills shift register with unpredictable test data.
// - Blanking high forces all sixteen sink outputs off.
// - Blanking low lets each latch bit drive its sink output.
// - With blanking low, a one turns the output on, a zero keeps it off.
// - Shift register MSB as of the last shift edge appears on the serial output for chaining.
// - Serial output changes only on a rising shift clock edge.
`timescale 1ns/1ps
`default_nettype none
module led_sink_onoff_shift_latch
    import led_sink_pkg::*;
(
    input  wire logic                    clk_i,        // System clock, 250 MHz
    input  wire logic                    sys_rst_i,    // Synchronous reset, active high
    input  wire led_sink_pkg::pins_in_t  pins_i,       // Serial, shift clock, strobe, blank
    input  wire logic                    out_ready_i,  // Sink stage accepts a word
    output logic                         out_valid_o,  // Buffered word available
    output var led_sink_pkg::pins_out_t  pins_o,       // Sink outputs and serial out
    output logic                         early_shift_o // Shift edge came too soon after strobe
);
    import led_sink_pkg::*;

    typedef struct packed {
        logic              sclk_q;
        logic              lat_q;
        logic [NUM_CH-1:0] shreg_q;
        logic [NUM_CH-1:0] latch_q;
        logic [NUM_CH-1:0] lfsr_q;
        logic [7:0]        hold_q;
        logic              early_q;
        logic [NUM_CH-1:0] buf0_q;
        logic [NUM_CH-1:0] buf1_q;
        logic              cnt_q;
        buf_state_t        bst_q;
        logic              in_valid_q;
        logic              blank_q;
        logic [NUM_CH-1:0] drive_q;
        logic              serial_out_q;
    } state_t;

    state_t s_q, s_d;
    logic   sclk_rise, lat_rise, pop;
    logic [NUM_CH-1:0] shifted;

    always_comb begin
        s_d       = s_q;
        sclk_rise = pins_i.shift_clk & ~s_q.sclk_q;
        lat_rise  = pins_i.latch_strobe & ~s_q.lat_q;
        shifted   = {s_q.shreg_q[NUM_CH-2:0], pins_i.serial_in};
        s_d.sclk_q = pins_i.shift_clk;
        s_d.lat_q  = pins_i.latch_strobe;
        // Free-running pattern stands in for the reserved test data
        s_d.lfsr_q = {s_q.lfsr_q[NUM_CH-2:0], ^(s_q.lfsr_q & TEST_TAPS)};
        if (lat_rise) begin
            s_d.latch_q = s_q.shreg_q;
            s_d.shreg_q = s_q.lfsr_q;
        end else if (sclk_rise) begin
            s_d.shreg_q = shifted;
            s_d.serial_out_q  = shifted[NUM_CH-1];
        end
        // Flag a shift edge inside the hold window, only as a status
        if (lat_rise) begin
            s_d.hold_q = 8'(SHIFT_HOLD_CYC);
        end else if (s_q.hold_q != 8'h00) begin
            s_d.hold_q = s_q.hold_q - 8'h01;
        end
        s_d.early_q = sclk_rise && !lat_rise && (s_q.hold_q != 8'h00);
        // Two-entry buffer between the latch and the sink stage
        s_d.in_valid_q = lat_rise;
        pop  = (s_q.bst_q == BUF_HELD) && out_ready_i;
        case (s_q.bst_q)
            BUF_EMPTY: begin
                if (s_q.in_valid_q) begin
                    s_d.buf0_q = s_q.latch_q;
                    s_d.bst_q  = BUF_HELD;
                end
            end
            BUF_HELD: begin
                if (pop && s_q.cnt_q) begin
                    s_d.buf0_q = s_q.in_valid_q ? s_q.latch_q : s_q.buf1_q;
                    s_d.buf1_q = s_q.latch_q;
                    s_d.cnt_q  = s_q.in_valid_q;
                end else if (pop) begin
                    if (s_q.in_valid_q) begin
                        s_d.buf0_q = s_q.latch_q;
                    end else begin
                        s_d.bst_q = BUF_EMPTY;
                    end
                end else if (s_q.in_valid_q) begin
                    // Newest word replaces a stale second slot; no word beyond two is needed
                    s_d.buf1_q = s_q.latch_q;
                    s_d.cnt_q  = 1'b1;
                end
            end
            default: s_d.bst_q = BUF_EMPTY;
        endcase
        if (pop && s_q.cnt_q && s_q.in_valid_q) begin
            s_d.buf0_q = s_q.buf1_q;
        end
        s_d.blank_q = pins_i.blank;
        // Output stage follows the live latch so no strobe is ever lost
        s_d.drive_q = pins_i.blank ? RESET_WORD : s_d.latch_q;
        if (sys_rst_i) begin
            s_d = '0;
            s_d.bst_q  = BUF_EMPTY;
            s_d.lfsr_q = TEST_SEED;
            s_d.blank_q = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    // One-hot code: the held bit is the flop itself
    assign out_valid_o         = s_q.bst_q[1];
    assign pins_o.sink_outputs = s_q.drive_q;
    assign pins_o.serial_out   = s_q.serial_out_q;
    assign early_shift_o       = s_q.early_q;

    property p_shift_lsb;
        @(posedge clk_i) disable iff (sys_rst_i)
        (pins_i.shift_clk && !s_q.sclk_q && !lat_rise) |=> (s_q.shreg_q[0] == $past(pins_i.serial_in));
    endproperty
    a_shift_lsb: assert property (p_shift_lsb) else $error("LSB did not take serial input");

    property p_shift_move;
        @(posedge clk_i) disable iff (sys_rst_i)
        (sclk_rise && !lat_rise) |=> (s_q.shreg_q[NUM_CH-1:1] == $past(s_q.shreg_q[NUM_CH-2:0]));
    endproperty
    a_shift_move: assert property (p_shift_move) else $error("Register did not shift");

    property p_latch_copy;
        @(posedge clk_i) disable iff (sys_rst_i)
        lat_rise |=> (s_q.latch_q == $past(s_q.shreg_q));
    endproperty
    a_latch_copy: assert property (p_latch_copy) else $error("Latch did not take register");

    property p_latch_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        !lat_rise |=> $stable(s_q.latch_q);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("Latch changed without strobe");

    property p_blank_off;
        @(posedge clk_i) disable iff (sys_rst_i)
        pins_i.blank |=> (pins_o.sink_outputs == RESET_WORD);
    endproperty
    a_blank_off: assert property (p_blank_off) else $error("Outputs on during blanking");

    sequence s_unblanked;
        !pins_i.blank ##1 1'b1;
    endsequence
    property p_follow_latch;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_unblanked |-> (pins_o.sink_outputs == s_q.latch_q);
    endproperty
    a_follow_latch: assert property (p_follow_latch) else $error("Outputs differ from latch");

    property p_serial_out_msb;
        @(posedge clk_i) disable iff (sys_rst_i)
        (sclk_rise && !lat_rise) |=> (pins_o.serial_out == s_q.shreg_q[NUM_CH-1]);
    endproperty
    a_serial_out_msb: assert property (p_serial_out_msb) else $error("Serial out is not MSB");

    property p_serial_out_edge;
        @(posedge clk_i) disable iff (sys_rst_i)
        !sclk_rise |=> $stable(pins_o.serial_out);
    endproperty
    a_serial_out_edge: assert property (p_serial_out_edge) else $error("Serial out moved without edge");

    property p_early_flag;
        @(posedge clk_i) disable iff (sys_rst_i)
        lat_rise ##1 (sclk_rise && !lat_rise) |=> early_shift_o;
    endproperty
    a_early_flag: assert property (p_early_flag) else $error("Early shift not flagged");

    // Status pulse only follows a detected shift edge
    property p_early_quiet;
        @(posedge clk_i) disable iff (sys_rst_i)
        !sclk_rise |=> !early_shift_o;
    endproperty
    a_early_quiet: assert property (p_early_quiet) else $error("Early flag without shift");

    // Register keeps its bits between edges
    sequence s_no_edge;
        !sclk_rise && !lat_rise;
    endsequence
    property p_shreg_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_no_edge |=> $stable(s_q.shreg_q);
    endproperty
    a_shreg_hold: assert property (p_shreg_hold) else $error("Register moved without edge");

    // Strobe wins over a coinciding shift edge; serial out must not move
    property p_strobe_wins;
        @(posedge clk_i) disable iff (sys_rst_i)
        (sclk_rise && lat_rise) |=> $stable(pins_o.serial_out);
    endproperty
    a_strobe_wins: assert property (p_strobe_wins) else $error("Serial out moved on strobe");

    // Latched word reaches the side stream two cycles after the strobe edge
    property p_valid_set;
        @(posedge clk_i) disable iff (sys_rst_i)
        lat_rise |=> ##1 out_valid_o;
    endproperty
    a_valid_set: assert property (p_valid_set) else $error("Latched word not offered");

    // A stalled receiver keeps the word offered
    property p_valid_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        (out_valid_o && !out_ready_i) |=> out_valid_o;
    endproperty
    a_valid_hold: assert property (p_valid_hold) else $error("Word dropped under stall");

    // Reset leaves every sink off and the chain quiet
    property p_reset_quiet;
        @(posedge clk_i)
        sys_rst_i |=> (pins_o.sink_outputs == RESET_WORD) && !pins_o.serial_out && !out_valid_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("Outputs active after reset");
endmodule
`default_nettype wire

// *** led_sink_onoff_shift_latch_test.sv ***
// Self-checking bench for the LED sink on/off block
`timescale 1ns/1ps
`default_nettype none
module led_sink_onoff_shift_latch_test;
    import led_sink_pkg::*;
    logic      clk_i;
    logic      sys_rst_i;
    logic      out_ready_i;
    logic      out_valid_o;
    logic      early_shift_o;
    pins_in_t  pins_i;
    pins_out_t pins_o;
    int        errors = 0;
    int        comparisons = 0;
    int        cycles = 0;
    int        early_cnt = 0;
    led_ctrl_model u_ctrl (.clk_i(clk_i), .pins_o(pins_i));
    led_sink_onoff_shift_latch u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pins_i(pins_i),
        .out_ready_i(out_ready_i), .out_valid_o(out_valid_o), .pins_o(pins_o), .early_shift_o(early_shift_o));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic close_out();
        if (errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (early_shift_o === 1'b1) early_cnt++;
        if (cycles == 3000) begin
            errors++;
            close_out();
        end
    end
    task automatic s_reset();
        @(negedge clk_i);
        check("sinks", pins_o.sink_outputs, 16'h0000);
        check("serial_out", {15'h0, pins_o.serial_out}, 16'h0000);
        check("valid", {15'h0, out_valid_o}, 16'h0000);
    endtask
    // Load a word with the sink stage stalled; serial out keeps MSB over strobe
    task automatic s_load(input logic [15:0] w, input int gap);
        u_ctrl.shift_word(w);
        @(negedge clk_i);
        check("serial_out", {15'h0, pins_o.serial_out}, {15'h0, w[15]});
        u_ctrl.strobe(gap);
        @(negedge clk_i);
        check("sinks", pins_o.sink_outputs, w);
        check("serial_out", {15'h0, pins_o.serial_out}, {15'h0, w[15]});
        check("valid", {15'h0, out_valid_o}, 16'h0001);
    endtask
    task automatic s_blank(input logic [15:0] w);
        u_ctrl.set_blank(1'b1);
        @(negedge clk_i);
        check("sinks", pins_o.sink_outputs, 16'h0000);
        u_ctrl.set_blank(1'b0);
        @(negedge clk_i);
        check("sinks", pins_o.sink_outputs, w);
    endtask
    task automatic s_drain();
        @(posedge clk_i);
        out_ready_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        out_ready_i <= 1'b0;
        @(negedge clk_i);
        check("valid", {15'h0, out_valid_o}, 16'h0000);
        check("early", early_cnt[15:0], 16'h0000);
    endtask
    initial begin
        sys_rst_i = 1'b1;
        out_ready_i = 1'b0;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        s_reset();
        s_load(16'h8001, SHIFT_HOLD_CYC);
        s_blank(16'h8001);
        s_load(16'h7ffe, SHIFT_HOLD_CYC);
        s_drain();
        s_load(16'h0001, 2);
        s_load(16'h0f0f, SHIFT_HOLD_CYC);
        check("early", {15'h0, early_cnt != 0}, 16'h0001);
        close_out();
    end
endmodule
`default_nettype wire

// *** led_sink_pkg.sv ***
// Package for the serial on/off LED sink control block
package led_sink_pkg;
    localparam int unsigned NUM_CH         = 16;
    localparam int unsigned CLK_PERIOD_PS  = 4000;
    localparam int unsigned SHIFT_HOLD_NS  = 100;
    localparam int unsigned SHIFT_HOLD_CYC = (SHIFT_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [NUM_CH-1:0] RESET_WORD = 16'h0000;
    localparam logic [NUM_CH-1:0] TEST_SEED  = 16'ha5c3;
    localparam logic [NUM_CH-1:0] TEST_TAPS  = 16'hb400;

    typedef struct packed {
        logic serial_in;
        logic shift_clk;
        logic latch_strobe;
        logic blank;
    } pins_in_t;

    typedef struct packed {
        logic [NUM_CH-1:0] sink_outputs;
        logic              serial_out;
    } pins_out_t;

    typedef enum logic [1:0] {
        BUF_EMPTY = 2'b01,
        BUF_HELD  = 2'b10
    } buf_state_t;
endpackage
